/* hdl/cond_sel.sv */
// antenna driver conductance select: register bank plus code selection
// assumes mod_active_i comes from the transmit encoder on CLK_I
`timescale 1ns/1ps
module cond_sel
  import cond_sel_pkg::*;
(
  // clock and reset
  input  wire logic       CLK_I,
  input  wire logic       RST_N_I,
  // register port
  input  wire logic [7:0] ADDR_I,
  input  wire logic [7:0] WDATA_I,
  input  wire logic       WR_I,
  input  wire logic       RD_I,
  output logic      [7:0] RDATA_O,
  // transmit encoder
  input  wire logic       MOD_ACTIVE_I,
  // driver codes
  output logic      [3:0] N_CODE_O,
  output logic      [5:0] P_CODE_O
);

  // ------------------------------------------------------------
  // register bank
  // ------------------------------------------------------------
  logic [7:0] n_on_q;
  logic [7:0] n_off_q;
  logic [5:0] p_cw_q;
  logic [5:0] p_mod_q;
  logic [3:0] ctrl_q;
  logic [7:0] rdata_q;

  wire sel_n_on  = (ADDR_I == N_ON_OFS);
  wire sel_p_cw  = (ADDR_I == P_CW_OFS);
  wire sel_p_mod = (ADDR_I == P_MOD_OFS);
  wire sel_n_off = (ADDR_I == N_OFF_OFS);
  wire sel_ctrl  = (ADDR_I == CTRL_OFS);
  wire sel_stat  = (ADDR_I == STATUS_OFS);

  // write enables, one per register except status; unmapped addresses hit none
  wire we_n_on  = WR_I & sel_n_on;
  wire we_p_cw  = WR_I & sel_p_cw;
  wire we_p_mod = WR_I & sel_p_mod;
  wire we_n_off = WR_I & sel_n_off;
  wire we_ctrl  = WR_I & sel_ctrl;

  // n-side on-state levels: upper nibble unmodulated, lower modulated
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      n_on_q <= N_ON_RST;
    end else if (we_n_on) begin
      n_on_q <= WDATA_I;
    end
  end

  // p-side levels: bits 7..6 reserved, dropped on write, read as zero
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      p_cw_q <= P_CW_RST[5:0];
    end else if (we_p_cw) begin
      p_cw_q <= WDATA_I[5:0];
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      p_mod_q <= P_MOD_RST[5:0];
    end else if (we_p_mod) begin
      p_mod_q <= WDATA_I[5:0];
    end
  end

  // off-state n levels, used only while both drivers are off
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      n_off_q <= N_OFF_RST;
    end else if (we_n_off) begin
      n_off_q <= WDATA_I;
    end
  end

  // control: output enables, full-depth ask, soft power-down
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      ctrl_q <= CTRL_RST[3:0];
    end else if (we_ctrl) begin
      ctrl_q <= WDATA_I[3:0];
    end
  end

  // ------------------------------------------------------------
  // selection
  // ------------------------------------------------------------
  wire drv_on    = ctrl_q[CTRL_OUTA] | ctrl_q[CTRL_OUTB];
  wire force_ask = ctrl_q[CTRL_F100];
  wire soft_pd   = ctrl_q[CTRL_SPD];

  wire [7:0] n_src    = drv_on ? n_on_q : n_off_q;
  wire [3:0] n_sel    = MOD_ACTIVE_I ? n_src[N_LO_MSB:N_LO_LSB]
                                     : n_src[N_HI_MSB:N_HI_LSB];
  // full-depth ASK: modulation P field ignored, P stays at its CW code
  wire       use_pmod = MOD_ACTIVE_I & ~force_ask;
  wire [5:0] p_sel    = use_pmod ? p_mod_q : p_cw_q;

  drive_code_s code_d;
  assign code_d.n_code = n_sel | {soft_pd, 3'h0};
  assign code_d.p_code = p_sel | {soft_pd, 5'h00};

  // registered so the codes never glitch between cw and modulation
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      N_CODE_O <= 4'h0;
      P_CODE_O <= 6'h00;
    end else begin
      N_CODE_O <= code_d.n_code;
      P_CODE_O <= code_d.p_code;
    end
  end

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  wire [7:0] rd_mux =
      sel_n_on  ? n_on_q :
      sel_p_cw  ? {P_RSVD_ZERO, p_cw_q} :
      sel_p_mod ? {P_RSVD_ZERO, p_mod_q} :
      sel_n_off ? n_off_q :
      sel_ctrl  ? {4'h0, ctrl_q} :
      sel_stat  ? {1'b0, MOD_ACTIVE_I, p_sel} :
                  8'h00;

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) rdata_q <= 8'h00;
    else          rdata_q <= RD_I ? rd_mux : 8'h00;
  end
  assign RDATA_O = rdata_q;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking

  // reset is released on an edge that still resets, so wait one more edge
  logic out_of_reset_q;
  always_ff @(posedge CLK_I) begin
    out_of_reset_q <= RST_N_I;
  end
  default disable iff (!RST_N_I || !out_of_reset_q);

  wire sel_none = ~(sel_n_on | sel_p_cw | sel_p_mod | sel_n_off | sel_ctrl | sel_stat);

  // ------------------------------------------------------------
  // code selection
  // ------------------------------------------------------------
  a_n_cw_sel: assert property (
    drv_on && !MOD_ACTIVE_I && !soft_pd |=>
    N_CODE_O == $past(n_on_q[7:4]))
    else $error("n cw code wrong");

  a_n_mod_sel: assert property (
    drv_on && MOD_ACTIVE_I && !soft_pd |=>
    N_CODE_O == $past(n_on_q[3:0]))
    else $error("n mod code wrong");

  a_n_off_sel: assert property (
    !drv_on && !soft_pd |=>
    N_CODE_O == ($past(MOD_ACTIVE_I) ? $past(n_off_q[3:0])
                                     : $past(n_off_q[7:4])))
    else $error("n off code wrong");

  a_p_cw_sel: assert property (
    !MOD_ACTIVE_I && !soft_pd |=>
    P_CODE_O == $past(p_cw_q))
    else $error("p cw code wrong");

  a_p_mod_sel: assert property (
    MOD_ACTIVE_I && !force_ask && !soft_pd |=>
    P_CODE_O == $past(p_mod_q))
    else $error("p mod code wrong");

  a_ask_ignore: assert property (
    force_ask && !soft_pd |=>
    P_CODE_O == $past(p_cw_q))
    else $error("mod p used in full ask");

  // ------------------------------------------------------------
  // power-down forcing
  // ------------------------------------------------------------
  a_pd_force: assert property (
    soft_pd |=>
    N_CODE_O[3] && P_CODE_O[5])
    else $error("power-down msb not forced");

  a_pd_n_low: assert property (
    soft_pd |=>
    N_CODE_O[2:0] == $past(n_sel[2:0]))
    else $error("power-down touched low n bits");

  a_pd_p_low: assert property (
    soft_pd |=>
    P_CODE_O[4:0] == $past(p_sel[4:0]))
    else $error("power-down touched low p bits");

  a_pd_keeps_store: assert property (
    soft_pd && !WR_I |=>
    $stable(n_on_q) && $stable(p_cw_q) && $stable(p_mod_q))
    else $error("power-down changed stored code");

  // ------------------------------------------------------------
  // following the modulation signal
  // ------------------------------------------------------------
  a_code_follow: assert property (
    $rose(MOD_ACTIVE_I) && drv_on && !soft_pd |=>
    N_CODE_O == $past(n_on_q[3:0]))
    else $error("code not following mod");

  a_code_fall: assert property (
    $fell(MOD_ACTIVE_I) && drv_on && !soft_pd |=>
    N_CODE_O == $past(n_on_q[7:4]))
    else $error("code not back to cw");

  a_p_follow_rise: assert property (
    $rose(MOD_ACTIVE_I) && !force_ask && !soft_pd |=>
    P_CODE_O == $past(p_mod_q))
    else $error("p code not following mod");

  a_p_follow_fall: assert property (
    $fell(MOD_ACTIVE_I) && !soft_pd |=>
    P_CODE_O == $past(p_cw_q))
    else $error("p code not back to cw");

  // ------------------------------------------------------------
  // register writes
  // ------------------------------------------------------------
  a_n_on_write: assert property (
    WR_I && sel_n_on ##1 RD_I && sel_n_on |=>
    RDATA_O == $past(WDATA_I, 2))
    else $error("n-on readback wrong");

  a_n_on_store: assert property (
    WR_I && sel_n_on |=>
    n_on_q == $past(WDATA_I))
    else $error("n-on write lost");

  a_n_off_write: assert property (
    WR_I && sel_n_off |=>
    n_off_q == $past(WDATA_I))
    else $error("n-off write lost");

  a_p_cw_write: assert property (
    WR_I && sel_p_cw |=>
    p_cw_q == $past(WDATA_I[5:0]))
    else $error("p cw write lost");

  a_p_mod_write: assert property (
    WR_I && sel_p_mod |=>
    p_mod_q == $past(WDATA_I[5:0]))
    else $error("p mod write lost");

  a_ctrl_write: assert property (
    WR_I && sel_ctrl |=>
    ctrl_q == $past(WDATA_I[3:0]))
    else $error("control write lost");

  a_hold_no_write: assert property (
    !WR_I |=>
    $stable(n_on_q) && $stable(n_off_q) && $stable(p_cw_q) &&
    $stable(p_mod_q) && $stable(ctrl_q))
    else $error("register changed without write");

  // ------------------------------------------------------------
  // read port
  // ------------------------------------------------------------
  a_p_rsvd_zero: assert property (
    RD_I && (sel_p_cw || sel_p_mod) |=>
    RDATA_O[7:6] == 2'h0)
    else $error("reserved p bits not zero");

  a_n_on_read: assert property (
    RD_I && sel_n_on |=>
    RDATA_O == $past(n_on_q))
    else $error("n-on read wrong");

  a_n_off_read: assert property (
    RD_I && sel_n_off |=>
    RDATA_O == $past(n_off_q))
    else $error("n-off read wrong");

  a_p_cw_read: assert property (
    RD_I && sel_p_cw |=>
    RDATA_O == {2'h0, $past(p_cw_q)})
    else $error("p cw read wrong");

  a_p_mod_read: assert property (
    RD_I && sel_p_mod |=>
    RDATA_O == {2'h0, $past(p_mod_q)})
    else $error("p mod read wrong");

  a_ctrl_read: assert property (
    RD_I && sel_ctrl |=>
    RDATA_O == {4'h0, $past(ctrl_q)})
    else $error("control read wrong");

  a_stat_read: assert property (
    RD_I && sel_stat |=>
    RDATA_O == {1'b0, $past(MOD_ACTIVE_I), $past(p_sel)})
    else $error("status read wrong");

  a_unmapped_read: assert property (
    RD_I && sel_none |=>
    RDATA_O == 8'h00)
    else $error("unmapped read not zero");

  a_rdata_idle: assert property (
    !RD_I |=>
    RDATA_O == 8'h00)
    else $error("read data not idle");

  // ------------------------------------------------------------
  // reset
  // ------------------------------------------------------------
  a_reset_values: assert property (
    disable iff (1'b0)
    !RST_N_I |=>
    n_on_q == N_ON_RST && p_cw_q == P_CW_RST[5:0] && p_mod_q == P_MOD_RST[5:0] &&
    n_off_q == N_OFF_RST && ctrl_q == CTRL_RST[3:0])
    else $error("register reset value wrong");

  a_reset_codes: assert property (
    disable iff (1'b0)
    !RST_N_I |=>
    N_CODE_O == 4'h0 && P_CODE_O == 6'h00 && RDATA_O == 8'h00)
    else $error("outputs not cleared by reset");

  // ------------------------------------------------------------
  // coverage
  // ------------------------------------------------------------
  c_mod_on: cover property (drv_on && MOD_ACTIVE_I);
  c_drv_off: cover property (!drv_on && MOD_ACTIVE_I);
  c_pd: cover property (soft_pd && MOD_ACTIVE_I);
  c_ask: cover property (force_ask && MOD_ACTIVE_I);
  c_wr_then_rd: cover property (WR_I ##1 RD_I);

endmodule : cond_sel

/* inc/cond_sel_pkg.sv */
// constants and carrier types for the antenna driver conductance select block
// assumes a plain address/strobe register port clocked on the core clock
package cond_sel_pkg;

  // register offsets
  localparam logic [7:0] N_ON_OFS     = 8'h27;
  localparam logic [7:0] P_CW_OFS     = 8'h28;
  localparam logic [7:0] P_MOD_OFS    = 8'h29;
  localparam logic [7:0] N_OFF_OFS    = 8'h2C;
  localparam logic [7:0] CTRL_OFS     = 8'h2D;
  localparam logic [7:0] STATUS_OFS   = 8'h2E;

  // reset values
  localparam logic [7:0] N_ON_RST     = 8'h88;
  localparam logic [7:0] P_CW_RST     = 8'h20;
  localparam logic [7:0] P_MOD_RST    = 8'h20;
  localparam logic [7:0] N_OFF_RST    = 8'h88;
  localparam logic [7:0] CTRL_RST     = 8'h00;

  // field positions
  localparam int N_HI_MSB  = 7;
  localparam int N_HI_LSB  = 4;
  localparam int N_LO_MSB  = 3;
  localparam int N_LO_LSB  = 0;
  localparam int P_MSB     = 5;
  localparam int CTRL_OUTA = 0;
  localparam int CTRL_OUTB = 1;
  localparam int CTRL_F100 = 2;
  localparam int CTRL_SPD  = 3;

  localparam logic [1:0] P_RSVD_ZERO = 2'h0;

  // effective codes toward the analog drivers
  typedef struct packed {
    logic [3:0] n_code;
    logic [5:0] p_code;
  } drive_code_s;

endpackage : cond_sel_pkg

/* test/tb_top.sv */
// self-checking bench for the conductance select block
// assumes read data one cycle after the strobe, codes two edges after a write
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; \
  $display("ERROR %0t bad value", $time); end end
module tb_top;
  import cond_sel_pkg::*;
  logic       clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0;
  logic       rd = 1'b0;
  logic       mod = 1'b0;
  logic [7:0] rdata;
  logic [3:0] n_code;
  logic [5:0] p_code;
  int         miscompares = 0;
  int         checks = 0;

  always #5 clk = ~clk;

  cond_sel cond_sel_inst (.CLK_I(clk), .RST_N_I(rst_n), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .MOD_ACTIVE_I(mod), .N_CODE_O(n_code),
    .P_CODE_O(p_code));

  // ----------------------------------------
  // bus and check helpers
  // ----------------------------------------
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, e)
  endtask : rd_chk

  // extra settle edge keeps the check clear of the write landing
  task automatic code_chk(input logic m, input logic [3:0] n, input logic [5:0] p);
    @(posedge clk);
    mod <= m;
    repeat (3) @(posedge clk);
    #1;
    `CHK(n_code, n)
    `CHK(p_code, p)
  endtask : code_chk

  task automatic conclude();
    if (miscompares == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    rd_chk(N_ON_OFS, 8'h88);
    rd_chk(P_CW_OFS, 8'h20);
    rd_chk(P_MOD_OFS, 8'h20);
    code_chk(1'b0, 4'h8, 6'h20);
  endtask : t_reset

  task automatic t_select();
    wr_reg(N_ON_OFS, 8'h5A);
    wr_reg(P_CW_OFS, 8'h15);
    wr_reg(P_MOD_OFS, 8'h0A);
    wr_reg(CTRL_OFS, 8'h01);
    code_chk(1'b0, 4'h5, 6'h15);
    code_chk(1'b1, 4'hA, 6'h0A);
    wr_reg(CTRL_OFS, 8'h02);
    code_chk(1'b0, 4'h5, 6'h15);
    wr_reg(N_OFF_OFS, 8'h3C);
    wr_reg(CTRL_OFS, 8'h00);
    code_chk(1'b0, 4'h3, 6'h15);
    code_chk(1'b1, 4'hC, 6'h0A);
  endtask : t_select

  task automatic t_force_pd();
    wr_reg(CTRL_OFS, 8'h05);
    code_chk(1'b1, 4'hA, 6'h15);
    wr_reg(CTRL_OFS, 8'h09);
    code_chk(1'b0, 4'hD, 6'h35);
    code_chk(1'b1, 4'hA, 6'h2A);
    rd_chk(N_ON_OFS, 8'h5A);
  endtask : t_force_pd

  // reserved bits and an unmapped place
  task automatic t_rsvd();
    wr_reg(P_MOD_OFS, 8'hFF);
    rd_chk(P_MOD_OFS, 8'h3F);
    wr_reg(8'h40, 8'h77);
    rd_chk(8'h40, 8'h00);
  endtask : t_rsvd

  // control and status readback, then a write and read with no gap
  task automatic t_readback();
    wr_reg(CTRL_OFS, 8'h01);
    code_chk(1'b1, 4'hA, 6'h3F);
    rd_chk(STATUS_OFS, 8'h7F);
    rd_chk(CTRL_OFS, 8'h01);
    @(posedge clk);
    addr <= N_ON_OFS;
    wdata <= 8'hC3;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    `CHK(rdata, 8'hC3)
    @(posedge clk);
    #1;
    `CHK(rdata, 8'h00)
  endtask : t_readback

  // reset in mid-run restores the registers and clears the outputs
  task automatic t_midreset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    `CHK(n_code, 4'h0)
    `CHK(p_code, 6'h00)
    @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(N_ON_OFS, 8'h88);
    rd_chk(P_MOD_OFS, 8'h20);
    code_chk(1'b0, 4'h8, 6'h20);
  endtask : t_midreset

  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_select();
    t_force_pd();
    t_rsvd();
    t_readback();
    t_midreset();
    conclude();
  end

  // about 110 cycles expected; nearly twenty times that margin
  initial begin
    #20000;
    miscompares++;
    conclude();
  end
endmodule : tb_top
